//--- fci_consts.svh
// timing counts, command codes and pin widths for the flash host controller
`ifndef FCI_CONSTS_SVH
`define FCI_CONSTS_SVH
`define FCI_CLK_PS 5000
`define FCI_ADDR_W 17
`define FCI_DATA_W 8
`define FCI_CMD_READ 8'h00
`define FCI_CMD_SIG 8'h90
`define FCI_CMD_ERASE 8'h20
`define FCI_CMD_ERASE_VFY 8'hA0
`define FCI_CMD_PROG 8'h40
`define FCI_CMD_PROG_VFY 8'hC0
`define FCI_CMD_RESET 8'hFF
`define FCI_ERASED_BYTE 8'hFF
`define FCI_ZERO_BYTE 8'h00
`define FCI_SIG_MFG_ADDR 17'h00000
`define FCI_SIG_DEV_ADDR 17'h00001
`define FCI_PROG_PULSE_NS 10000
`define FCI_ERASE_PULSE_NS 9500000
`define FCI_RECOVERY_NS 6000
`define FCI_STROBE_NS 40
`define FCI_STROBE_HIGH_NS 20
`define FCI_READ_NS 120
`define FCI_MAX_PROG_LOOPS 25
`define FCI_MAX_ERASE_LOOPS 1000
`define FCI_CNT_W 24
`define FCI_LOOP_W 10
`endif

//--- fci_pkg.sv
// types for the flash host controller
package fci_pkg;
	typedef enum logic [3:0] {
		FCI_OP_READ = 4'h0,
		FCI_OP_SIG = 4'h1,
		FCI_OP_PROG = 4'h2,
		FCI_OP_ERASE = 4'h3,
		FCI_OP_RESET = 4'h4,
		FCI_OP_HVSIG = 4'h5
	} fci_op_t;
	typedef struct packed {
		fci_op_t op;
		logic [16:0] addr;
		logic [7:0] data;
	} fci_req_t;
	typedef struct packed {
		logic ceN;
		logic oeN;
		logic weN;
		logic vppHigh;
		logic sigHv;
		logic [16:0] addr;
	} fci_pins_t;
	typedef enum logic [1:0] {
		FCI_BUS_WRITE = 2'h1,
		FCI_BUS_READ = 2'h2
	} fci_bus_t;
endpackage

//--- fci_bus_cycle.sv
// one timed write or read cycle on the flash pins
`timescale 1ns/1ps
`include "fci_consts.svh"
module fci_bus_cycle (
	input wire logic mclk,
	input wire logic rst,
	input wire logic start,
	input wire fci_pkg::fci_bus_t kind,
	input wire logic [7:0] wrData,
	input wire logic [7:0] dataIn,
	output logic weN,
	output logic oeN,
	output logic dataOe,
	output logic [7:0] dataOut,
	output logic [7:0] rdData,
	output logic done
);
	import fci_pkg::*;
	localparam int STROBE_CYC = (`FCI_STROBE_NS * 1000 + `FCI_CLK_PS - 1) / `FCI_CLK_PS;
	localparam int HIGH_CYC = (`FCI_STROBE_HIGH_NS * 1000 + `FCI_CLK_PS - 1) / `FCI_CLK_PS;
	localparam int READ_CYC = (`FCI_READ_NS * 1000 + `FCI_CLK_PS - 1) / `FCI_CLK_PS;
	logic [7:0] cnt_q;
	logic busy_q;
	logic isRead_q;
	wire logic lowDone = busy_q && (cnt_q == 8'(isRead_q ? READ_CYC : STROBE_CYC));
	wire logic highDone = !busy_q && (cnt_q != 8'h00) && (cnt_q == 8'(HIGH_CYC));
	// data pins sampled through three stages, stable when last two agree
	logic [7:0] s1_q, s2_q, s3_q, dStable_q;
	always_ff @(posedge mclk) begin
		s1_q <= dataIn;
		s2_q <= s1_q;
		s3_q <= s2_q;
		// a byte still settling keeps the last agreed value
		if (s2_q == s3_q) begin
			dStable_q <= s3_q;
		end
	end
	always_ff @(posedge mclk) begin
		if (rst) begin
			cnt_q <= 8'h00;
			busy_q <= 1'b0;
			isRead_q <= 1'b0;
			weN <= 1'b1;
			oeN <= 1'b1;
			dataOe <= 1'b0;
			dataOut <= 8'h00;
			rdData <= 8'h00;
			done <= 1'b0;
		end else begin
			done <= 1'b0;
			if (start && !busy_q && cnt_q == 8'h00) begin
				busy_q <= 1'b1;
				cnt_q <= 8'h01;
				isRead_q <= (kind == FCI_BUS_READ);
				weN <= (kind == FCI_BUS_READ);
				oeN <= (kind != FCI_BUS_READ);
				dataOe <= (kind != FCI_BUS_READ);
				dataOut <= wrData;
			end else if (lowDone) begin
				// rising strobe edge latches the command in the flash
				busy_q <= 1'b0;
				cnt_q <= 8'h01;
				weN <= 1'b1;
				oeN <= 1'b1;
				if (isRead_q) begin
					rdData <= dStable_q;
				end
			end else if (highDone) begin
				// data held one high phase for hold time
				cnt_q <= 8'h00;
				dataOe <= 1'b0;
				done <= 1'b1;
			end else if (cnt_q != 8'h00) begin
				cnt_q <= cnt_q + 8'h01;
			end
		end
	end
endmodule

//--- fci_host.sv
// host sequencer driving the flash command interface
// Summary of operation
// - with supply high, issue set-read before reading array data
// - after 90H, read address 0 for maker, 1 for device id
// - high-voltage signature: raise address line nine, other lines low, read; the host drives bit zero from the request to pick maker or device
// - wait 6 us after program or erase cycle before reading
// - at most 25 program-verify loops per byte, then fail
// - program every byte to 00H before chip erase; the host does not do this and leaves it to the requester
// - erase starts only after two consecutive 20H writes
// - A0H ends erase pulse, verify address latched on falling strobe
// - 40H then address-and-data write cycle starts programming
// - two FFH writes abort and return flash to read mode
`timescale 1ns/1ps
`include "fci_consts.svh"
module fci_host (
	input wire logic mclk,
	input wire logic rst,
	input wire logic reqValid,
	input wire fci_pkg::fci_req_t req,
	output logic reqReady,
	output logic rspValid,
	output logic [7:0] rspData,
	output logic rspFail,
	output fci_pkg::fci_pins_t pins,
	input wire logic [7:0] dataIn,
	output logic [7:0] dataOut,
	output logic dataOe
);
	import fci_pkg::*;
	localparam int PROG_CYC = (`FCI_PROG_PULSE_NS * 1000 + `FCI_CLK_PS - 1) / `FCI_CLK_PS;
	// erase figure in picoseconds overflows 32 bits, so it is reckoned wide
	localparam int ERASE_CYC = int'((longint'(`FCI_ERASE_PULSE_NS) * 1000 + `FCI_CLK_PS - 1) / `FCI_CLK_PS);
	localparam int RECOV_CYC = (`FCI_RECOVERY_NS * 1000 + `FCI_CLK_PS - 1) / `FCI_CLK_PS;
	parameter int ERASE_WAIT = ERASE_CYC;
	parameter int PROG_WAIT = PROG_CYC;
	parameter int RECOV_WAIT = RECOV_CYC;
	typedef enum logic [9:0] {
		ST_IDLE = 10'h001,
		ST_CMD1 = 10'h002,
		ST_CMD2 = 10'h004,
		ST_PULSE = 10'h008,
		ST_VFY = 10'h010,
		ST_RECOV = 10'h020,
		ST_READ = 10'h040,
		ST_CHECK = 10'h080,
		ST_DONE = 10'h100,
		ST_PREP = 10'h200
	} fci_state_t;
	fci_state_t state_q;
	fci_req_t cur_q;
	logic [`FCI_CNT_W-1:0] wait_q;
	logic [`FCI_LOOP_W-1:0] loops_q;
	logic [16:0] eraseAddr_q;
	logic cycStart_q;
	fci_bus_t cycKind_q;
	logic [7:0] cycData_q;
	logic [7:0] rdData;
	logic cycDone;
	logic weN;
	logic oeN;
	logic bOe;
	logic [7:0] bOut;
	fci_bus_cycle u_cycle (
		.mclk(mclk),
		.rst(rst),
		.start(cycStart_q),
		.kind(cycKind_q),
		.wrData(cycData_q),
		.dataIn(dataIn),
		.weN(weN),
		.oeN(oeN),
		.dataOe(bOe),
		.dataOut(bOut),
		.rdData(rdData),
		.done(cycDone)
	);
	wire logic isProg = (cur_q.op == FCI_OP_PROG);
	wire logic isErase = (cur_q.op == FCI_OP_ERASE);
	wire logic twoCycle = isProg || isErase || (cur_q.op == FCI_OP_RESET);
	wire logic lastAddr = (eraseAddr_q == 17'h1FFFF);
	wire logic progOk = (rdData == cur_q.data);
	wire logic eraseOk = (rdData == `FCI_ERASED_BYTE);
	wire logic loopsOut = isProg ? (loops_q >= `FCI_LOOP_W'(`FCI_MAX_PROG_LOOPS))
		: (loops_q >= `FCI_LOOP_W'(`FCI_MAX_ERASE_LOOPS));
	// first command byte per operation
	wire logic [7:0] cmd1 = isProg ? `FCI_CMD_PROG : isErase ? `FCI_CMD_ERASE
		: (cur_q.op == FCI_OP_RESET) ? `FCI_CMD_RESET
		: (cur_q.op == FCI_OP_SIG) ? `FCI_CMD_SIG : `FCI_CMD_READ;
	wire logic [7:0] cmd2 = isProg ? cur_q.data : cmd1;
	wire logic [7:0] vfyCmd = isProg ? `FCI_CMD_PROG_VFY : `FCI_CMD_ERASE_VFY;
	wire logic needsCmd = (cur_q.op != FCI_OP_HVSIG);
	always_ff @(posedge mclk) begin
		if (rst) begin
			state_q <= ST_IDLE;
			cur_q <= '0;
			wait_q <= '0;
			loops_q <= '0;
			eraseAddr_q <= '0;
			cycStart_q <= 1'b0;
			cycKind_q <= FCI_BUS_WRITE;
			cycData_q <= 8'h00;
			reqReady <= 1'b0;
			rspValid <= 1'b0;
			rspData <= 8'h00;
			rspFail <= 1'b0;
			pins <= '{ceN: 1'b1, oeN: 1'b1, weN: 1'b1, vppHigh: 1'b0, sigHv: 1'b0, addr: '0};
			dataOut <= 8'h00;
			dataOe <= 1'b0;
		end else begin
			cycStart_q <= 1'b0;
			rspValid <= 1'b0;
			reqReady <= (state_q == ST_IDLE) && !(reqValid && reqReady);
			pins.weN <= weN;
			pins.oeN <= oeN;
			dataOut <= bOut;
			dataOe <= bOe;
			case (state_q)
				ST_IDLE: begin
					// idle bus keeps the flash in standby
					pins.ceN <= 1'b1;
					pins.sigHv <= 1'b0;
					if (reqValid && reqReady) begin
						cur_q <= req;
						// stale pulse count from a reset sequence would block the first cycle
						wait_q <= '0;
						loops_q <= '0;
						eraseAddr_q <= '0;
						pins.ceN <= 1'b0;
						// supply raised for any command write
						pins.vppHigh <= (req.op != FCI_OP_HVSIG);
						state_q <= ST_CMD1;
					end
				end
				ST_CMD1: begin
					if (!needsCmd) begin
						// high-voltage line nine, others low except bit zero
						pins.sigHv <= 1'b1;
						pins.addr <= {16'h0000, cur_q.addr[0]};
						state_q <= ST_READ;
					end else if (!cycStart_q && wait_q == '0) begin
						// first bus cycle carries the command byte
						cycKind_q <= FCI_BUS_WRITE;
						cycData_q <= cmd1;
						cycStart_q <= 1'b1;
						wait_q <= `FCI_CNT_W'(1);
					end else if (cycDone) begin
						wait_q <= '0;
						// set-read or signature command before reads
						state_q <= twoCycle ? ST_CMD2 : ST_READ;
						if (cur_q.op == FCI_OP_SIG) begin
							pins.addr <= cur_q.addr[0] ? `FCI_SIG_DEV_ADDR : `FCI_SIG_MFG_ADDR;
						end else begin
							pins.addr <= cur_q.addr;
						end
						if (isErase) begin
							pins.addr <= eraseAddr_q;
						end
					end
				end
				ST_CMD2: begin
					if (!cycStart_q && wait_q == '0) begin
						// second identical 20H; data write; second FFH
						cycKind_q <= FCI_BUS_WRITE;
						cycData_q <= cmd2;
						cycStart_q <= 1'b1;
						wait_q <= `FCI_CNT_W'(1);
					end else if (cycDone) begin
						loops_q <= loops_q + `FCI_LOOP_W'(1);
						// stop-timer pulse waits its full minimum
						wait_q <= isProg ? `FCI_CNT_W'(PROG_WAIT) : `FCI_CNT_W'(ERASE_WAIT);
						state_q <= (cur_q.op == FCI_OP_RESET) ? ST_DONE : ST_PULSE;
					end
				end
				ST_PULSE: begin
					if (wait_q != '0) begin
						wait_q <= wait_q - `FCI_CNT_W'(1);
					end else begin
						state_q <= ST_VFY;
					end
				end
				ST_VFY: begin
					if (!cycStart_q && wait_q == '0) begin
						// A0H ends erase, address latched; C0H ends program
						pins.addr <= isProg ? cur_q.addr : eraseAddr_q;
						cycKind_q <= FCI_BUS_WRITE;
						cycData_q <= vfyCmd;
						cycStart_q <= 1'b1;
						wait_q <= `FCI_CNT_W'(1);
					end else if (cycDone) begin
						wait_q <= `FCI_CNT_W'(RECOV_WAIT);
						state_q <= ST_RECOV;
					end
				end
				ST_RECOV: begin
					if (wait_q != '0) begin
						wait_q <= wait_q - `FCI_CNT_W'(1);
					end else begin
						state_q <= ST_READ;
					end
				end
				ST_READ: begin
					if (!cycStart_q && wait_q == '0) begin
						// output enable low, strobe high; satisfied by set-read
						cycKind_q <= FCI_BUS_READ;
						cycStart_q <= 1'b1;
						wait_q <= `FCI_CNT_W'(1);
					end else if (cycDone) begin
						wait_q <= '0;
						state_q <= (isProg || isErase) ? ST_CHECK : ST_DONE;
					end
				end
				ST_CHECK: begin
					if (isProg && progOk) begin
						state_q <= ST_DONE;
					end else if (isErase && eraseOk && lastAddr) begin
						state_q <= ST_DONE;
					end else if (isErase && eraseOk) begin
						// next byte verified without a new pulse
						eraseAddr_q <= eraseAddr_q + 17'h00001;
						state_q <= ST_VFY;
					end else if (loopsOut) begin
						rspFail <= 1'b1;
						state_q <= ST_PREP;
					end else begin
						state_q <= ST_CMD1;
					end
				end
				ST_PREP: begin
					// abort leftover operation with the double FFH reset
					cur_q.op <= FCI_OP_RESET;
					state_q <= ST_CMD1;
				end
				ST_DONE: begin
					rspValid <= 1'b1;
					rspData <= rdData;
					pins.vppHigh <= 1'b0;
					pins.sigHv <= 1'b0;
					pins.ceN <= 1'b1;
					state_q <= ST_IDLE;
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
			if (state_q == ST_IDLE && reqValid && reqReady) begin
				rspFail <= 1'b0;
			end
		end
	end
	// chip erase expects every byte already programmed to 00H by the requester
	chk_prog_loops: assert property (@(posedge mclk) disable iff (rst)
		(state_q == ST_CMD2 && isProg) |-> loops_q < `FCI_LOOP_W'(`FCI_MAX_PROG_LOOPS))
		else $error("program loop count exceeded");
	chk_supply_write: assert property (@(posedge mclk) disable iff (rst)
		$fell(pins.weN) && !pins.sigHv |-> pins.vppHigh)
		else $error("write strobe without program supply");
	chk_read_levels: assert property (@(posedge mclk) disable iff (rst)
		!pins.oeN |-> pins.weN && !pins.ceN)
		else $error("read cycle with bad control levels");
	chk_standby_release: assert property (@(posedge mclk) disable iff (rst)
		pins.ceN |-> !dataOe)
		else $error("data driven in standby");
	chk_pulse_length: assert property (@(posedge mclk) disable iff (rst)
		(state_q == ST_CMD2 && cycDone && isProg) |=> (state_q == ST_PULSE)[*8])
		else $error("program pulse cut short");
	chk_recovery_wait: assert property (@(posedge mclk) disable iff (rst)
		(state_q == ST_VFY && cycDone) |=> (state_q == ST_RECOV)[*8])
		else $error("read too soon after write");
	chk_sig_lines: assert property (@(posedge mclk) disable iff (rst)
		pins.sigHv |-> pins.addr[16:1] == 16'h0000)
		else $error("signature address lines not low");
	chk_vfy_follows: assert property (@(posedge mclk) disable iff (rst)
		(state_q == ST_PULSE && wait_q == '0) |=> state_q == ST_VFY)
		else $error("verify command not issued after pulse");
endmodule

//--- fci_flash_model.sv
// behavioural flash device answering the host controller pins
`timescale 1ns/1ps
module fci_flash_model #(
	parameter logic [7:0] MAKER_ID = 8'h5C, // arbitrary value
	parameter logic [7:0] PART_ID = 8'h6D, // arbitrary value
	parameter realtime PULSE_NS = 100.0,
	parameter realtime RECOV_NS = 100.0
) (
	input wire fci_pkg::fci_pins_t pins,
	input wire logic [7:0] busIn,
	input wire logic [16:0] stuckAddr,
	output logic [7:0] flashOut
);
	import fci_pkg::*;
	logic [7:0] mem [int];
	// power-up mode is array read
	logic [7:0] cmd = 8'h00;
	logic [16:0] addrLat = '0;
	logic [16:0] pendAddr = '0;
	logic [7:0] pgData = 8'h00;
	logic [7:0] rdByte = 8'h00;
	logic [7:0] lastOut = 8'h00;
	realtime pulseStart = 0.0;
	realtime endWrite = -1.0e6;
	int violations = 0;
	int eraseStarts = 0;
	int progPulses = 0;
	int aborts = 0;

	function automatic logic [7:0] memRd(input logic [16:0] a);
		return mem.exists(a) ? mem[a] : 8'hFF;
	endfunction

	// released lines show the inverse of the last byte, never a stale copy
	assign flashOut = (!pins.ceN && !pins.oeN && pins.weN) ? rdByte : ~lastOut;

	// address taken on the falling strobe
	always @(negedge pins.weN) if (!pins.ceN) pendAddr = pins.addr;

	always @(posedge pins.weN) begin
		if (!pins.ceN) begin
			// a write with the supply low is a host fault
			if (!pins.vppHigh) violations++;
			// second program cycle takes data on the rising strobe
			else if (cmd == 8'h40) begin
				addrLat = pendAddr;
				pgData = busIn;
				cmd = 8'h41;
				pulseStart = $realtime;
				endWrite = $realtime;
				progPulses++;
			end
			// two resets in a row abort
			else if (busIn == 8'hFF && cmd == 8'hFF) begin
				aborts++;
				cmd = 8'h00;
			end
			// erase only on the second 20H
			else if (busIn == 8'h20 && cmd == 8'h20) begin
				eraseStarts++;
				pulseStart = $realtime;
				endWrite = $realtime;
				cmd = 8'h21;
			end else begin
				// stop timer demands a minimum pulse
				if ((busIn == 8'hA0 || busIn == 8'hC0) && $realtime - pulseStart < PULSE_NS) violations++;
				// verify write ends the operation, recovery counts from here
				if (busIn == 8'hA0 || busIn == 8'hC0) endWrite = $realtime;
				// stuck cell never takes its data, so the host must retry
				if (busIn == 8'hC0 && cmd == 8'h41 && addrLat != stuckAddr) mem[addrLat] = pgData;
				// verify code ends the erase pulse
				if (busIn == 8'hA0) begin
					if (cmd == 8'h21) mem.delete();
					addrLat = pendAddr;
				end
				cmd = busIn;
			end
		end
	end

	always @(negedge pins.oeN or negedge pins.ceN) begin
		if (!pins.ceN && !pins.oeN) begin
			// reading too soon after a program or erase cycle
			if ($realtime - endWrite < RECOV_NS) violations++;
			// signature by command or by raised line nine
			if ((pins.sigHv && (pins.addr & ~17'h00201) == 17'h0) || (pins.vppHigh && cmd == 8'h90))
				rdByte = pins.addr[0] ? PART_ID : MAKER_ID;
			// verify reads use the latched address
			else if (pins.vppHigh && (cmd == 8'hA0 || cmd == 8'hC0))
				rdByte = memRd(addrLat);
			// array data only in read mode or with the supply low
			else if (!pins.vppHigh || cmd == 8'h00)
				rdByte = memRd(pins.addr);
			else
				rdByte = ~lastOut;
		end
	end

	always @(posedge pins.oeN) lastOut = rdByte;
endmodule

//--- test_fci_host.sv
// self-checking bench for the flash host controller
`timescale 1ns/1ps
module test_fci_host;
	import fci_pkg::*;
	localparam int PW = 20;
	localparam logic [7:0] MAKER = 8'h5C;
	localparam logic [7:0] PART = 8'h6D;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic reqValid = 1'b0;
	fci_req_t req = '0;
	logic reqReady;
	logic rspValid;
	logic rspFail;
	logic dataOe;
	logic [7:0] rspData;
	logic [7:0] dataOut;
	logic [7:0] flashOut;
	fci_pins_t pins;
	logic [16:0] stuckAddr = 17'h1FFFF;
	logic [9:0] expQ[$];
	logic [9:0] e;
	logic [16:0] pa[4];
	logic [7:0] pd[4];
	int n0;
	int num_errors = 0;
	int checks = 0;
	wire [7:0] busLvl = dataOe ? dataOut : flashOut;

	always #2.5 mclk = ~mclk;

	fci_host #(.ERASE_WAIT(PW * 2), .PROG_WAIT(PW), .RECOV_WAIT(PW)) i_fci_host (
		.mclk(mclk), .rst(rst), .reqValid(reqValid), .req(req), .reqReady(reqReady), .rspValid(rspValid),
		.rspData(rspData), .rspFail(rspFail), .pins(pins), .dataIn(busLvl), .dataOut(dataOut), .dataOe(dataOe));
	fci_flash_model #(.MAKER_ID(MAKER), .PART_ID(PART), .PULSE_NS(PW * 5.0), .RECOV_NS(PW * 5.0)) i_fci_flash_model (
		.pins(pins), .busIn(busLvl), .stuckAddr(stuckAddr), .flashOut(flashOut));

	task automatic compare(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic print_verdict();
		$display("checks %0d num_errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// ex: {data compared, fail, data}; wt low leaves the operation running
	task automatic run(input fci_op_t op, input logic [16:0] ad, input logic [7:0] dt, input logic [9:0] ex, input bit wt);
		int n;
		n = 0;
		if (wt) expQ.push_back(ex);
		@(negedge mclk);
		reqValid = 1'b1;
		req = {op, ad, dt};
		@(posedge mclk);
		while (reqReady !== 1'b1 && n < 100) begin
			n++;
			@(posedge mclk);
		end
		compare({7'h0, reqReady}, 8'h01);
		@(negedge mclk);
		reqValid = 1'b0;
		n = 0;
		while (wt && rspValid !== 1'b1 && n < 20000) begin
			n++;
			@(posedge mclk);
		end
		if (wt) compare({7'h0, rspValid}, 8'h01);
	endtask

	// oldest note is matched against each answer
	always @(posedge mclk) begin
		if (rspValid === 1'b1) begin
			if (expQ.size() == 0) begin
				num_errors++;
				$display("mismatch at %0t: got %h expected %h", $time, rspData, 8'h00);
			end else begin
				e = expQ.pop_front();
				compare({7'h0, rspFail}, {7'h0, e[8]});
				if (e[9]) compare(rspData, e[7:0]);
			end
		end
	end

	initial begin
		void'($urandom(67149));
		fork
			begin
				#250000;
				num_errors++;
				print_verdict();
			end
		join_none
		repeat (6) @(posedge mclk);
		@(negedge mclk);
		rst = 1'b0;
		compare({4'h0, pins.ceN, pins.oeN, pins.weN, pins.vppHigh}, 8'h0E);
		for (int k = 0; k < 2; k++) begin
			run(FCI_OP_SIG, 17'(k), 8'h00, {2'b10, k ? PART : MAKER}, 1);
			run(FCI_OP_HVSIG, 17'(k), 8'h00, {2'b10, k ? PART : MAKER}, 1);
		end
		// read right after signature mode must first restore read mode
		run(FCI_OP_SIG, 17'h00000, 8'h00, {2'b10, MAKER}, 1);
		run(FCI_OP_READ, 17'h00123, 8'h00, {2'b10, 8'hFF}, 1);
		for (int k = 0; k < 4; k++) begin
			pa[k] = {1'b0, 12'($urandom), 4'(k)};
			pd[k] = 8'($urandom);
			run(FCI_OP_PROG, pa[k], pd[k], 10'h000, 1);
		end
		for (int k = 0; k < 4; k++) run(FCI_OP_READ, pa[k], 8'h00, {2'b10, pd[k]}, 1);
		stuckAddr = 17'h10ABC;
		n0 = i_fci_flash_model.progPulses;
		run(FCI_OP_PROG, stuckAddr, 8'h5A, 10'h100, 1);
		compare(8'(i_fci_flash_model.progPulses - n0), 8'h19);
		n0 = i_fci_flash_model.aborts;
		run(FCI_OP_RESET, 17'h00000, 8'h00, 10'h000, 1);
		compare(8'(i_fci_flash_model.aborts - n0), 8'h01);
		n0 = i_fci_flash_model.eraseStarts;
		run(FCI_OP_ERASE, 17'h00000, 8'h00, 10'h000, 0);
		repeat (2000) begin
			if (i_fci_flash_model.cmd !== 8'hA0) @(posedge mclk);
		end
		compare(i_fci_flash_model.cmd, 8'hA0);
		compare(8'(i_fci_flash_model.eraseStarts - n0), 8'h01);
		// full verify sweep is too long, so the erase is cut by reset
		@(negedge mclk);
		rst = 1'b1;
		repeat (PW) @(negedge mclk);
		rst = 1'b0;
		compare({4'h0, pins.ceN, pins.oeN, pins.weN, pins.vppHigh}, 8'h0E);
		run(FCI_OP_READ, pa[0], 8'h00, {2'b10, 8'hFF}, 1);
		compare(8'(i_fci_flash_model.violations), 8'h00);
		print_verdict();
	end
endmodule
